// ### lpd_core.sv
// Device-side power-down, deep power-down and impedance calibration logic.
`timescale 1ns/10ps
`include "lpd_params.svh"
module lpd_core import lpd_pkg::*; #(
  parameter int INIT_CYC = `INIT_CAL_CYC,
  parameter int LONG_CYC = `LONG_CAL_CYC,
  parameter int SHORT_CYC = `SHORT_CAL_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_gate,
  input wire logic select_n,
  input wire logic [3:0] cmd_rise,
  input wire logic [7:0] mode_addr,
  input wire logic [7:0] mode_data,
  input wire logic row_open,
  input wire logic impedance_ref_pin,
  input wire logic init_done,
  output logic buffers_on,
  output logic pd_idle,
  output logic pd_active,
  output logic in_deep_sleep,
  output logic need_reinit,
  output logic cal_busy,
  output logic refresh_allowed,
  output logic impedance_calibrated
);
  logic [14:0] sync_in;
  logic [14:0] sync_out;
  logic gate;
  logic sel_n;
  logic [3:0] cmd;
  logic [7:0] maddr;
  logic ref_tied;
  logic open;
  pwr_state_e state;
  logic [`CAL_CNT_W-1:0] cal_cnt;
  logic cal_req;
  logic [`CAL_CNT_W-1:0] cal_len;
  logic imp_reset_req;
  logic last_nop;
  logic cmd_strobe;

  // Mode data bypasses the synchroniser and is used directly, unlike the address; it is held stable by the controller.
  assign sync_in = {clk_gate, select_n, cmd_rise, mode_addr, impedance_ref_pin};
  cmd_sync #(.W(15)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .din(sync_in),
    .dout(sync_out)
  );
  assign gate = sync_out[14];
  assign sel_n = sync_out[13];
  assign cmd = sync_out[12:9];
  assign maddr = sync_out[8:1];
  assign ref_tied = sync_out[0];
  assign open = row_open;

  function automatic logic is_mode_write(input logic s_n, input logic [3:0] c);
    return !s_n && (c == 4'h0);
  endfunction

  function automatic logic is_nop(input logic s_n, input logic [3:0] c);
    return s_n || (c[2:0] == 3'h7);
  endfunction

  // The controller holds a command for several cycles so that it passes the synchroniser.
  // It counts once, on the first cycle it is seen, so a held mode write cannot start a second calibration.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      last_nop <= 1'b1;
    end else begin
      last_nop <= is_nop(sel_n, cmd);
    end
  end
  assign cmd_strobe = !is_nop(sel_n, cmd) && last_nop;

  // Calibration decode; a tied reference pin makes all calibration codes ignored.
  always_comb begin
    cal_req = 1'b0;
    imp_reset_req = 1'b0;
    cal_len = '0;
    if (gate && state == st_idle && cmd_strobe && is_mode_write(sel_n, cmd) &&
        maddr == `CAL_MODE_ADDR && !ref_tied) begin
      case (mode_data)
        `CAL_CODE_INIT: begin
          cal_req = 1'b1;
          cal_len = `CAL_CNT_W'(INIT_CYC);
        end
        `CAL_CODE_LONG: begin
          cal_req = 1'b1;
          cal_len = `CAL_CNT_W'(LONG_CYC);
        end
        `CAL_CODE_SHORT: begin
          cal_req = 1'b1;
          cal_len = `CAL_CNT_W'(SHORT_CYC);
        end
        `CAL_CODE_RESET: imp_reset_req = 1'b1;
        default: begin
          cal_req = 1'b0;
        end
      endcase
    end
  end

  // Power state machine.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle, st_active: begin
          if (!gate && !sel_n && cmd[2:0] == 3'h3) begin
            state <= st_deep;
          end else if (!gate && sel_n) begin
            state <= open ? st_active_pd : st_idle_pd;
          end else if (cal_req) begin
            state <= st_cal;
          end else begin
            state <= open ? st_active : st_idle;
          end
        end
        st_cal: begin
          if (cal_cnt == `CAL_CNT_W'(1)) begin
            state <= st_idle;
          end
        end
        st_idle_pd, st_active_pd: begin
          if (gate && sel_n) begin
            state <= (state == st_active_pd) ? st_active : st_idle;
          end
        end
        st_deep: begin
          if (init_done) begin
            state <= st_idle;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cal_cnt <= '0;
    end else if (state != st_cal && cal_req) begin
      cal_cnt <= cal_len;
    end else if (cal_cnt != '0) begin
      cal_cnt <= cal_cnt - `CAL_CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      impedance_calibrated <= 1'b0;
    end else if (state == st_cal && cal_cnt == `CAL_CNT_W'(1)) begin
      impedance_calibrated <= 1'b1;
    end else if (imp_reset_req || state == st_deep) begin
      impedance_calibrated <= 1'b0;
    end
  end

  // Outputs are registered decodes of the state; need_reinit is also gated by init_done.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      buffers_on <= 1'b1;
      pd_idle <= 1'b0;
      pd_active <= 1'b0;
      in_deep_sleep <= 1'b0;
      need_reinit <= 1'b0;
      cal_busy <= 1'b0;
      refresh_allowed <= 1'b1;
    end else begin
      buffers_on <= !(state inside {st_idle_pd, st_active_pd, st_deep});
      pd_idle <= state == st_idle_pd;
      pd_active <= state == st_active_pd;
      in_deep_sleep <= state == st_deep;
      need_reinit <= (state == st_deep) && !init_done;
      cal_busy <= state == st_cal;
      refresh_allowed <= state inside {st_idle, st_active};
    end
  end

  a_cal_gate_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == st_cal |-> gate) else $error("gate low during calibration");
  a_cal_nop_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == st_cal |-> !cmd_strobe) else $error("command during calibration");
  a_pd_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == st_idle && !gate && sel_n && !open |=> state == st_idle_pd ##1 !buffers_on)
    else $error("power-down entry missed");
  a_active_pd: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == st_active && !gate && sel_n && open |=> ##1 pd_active) else $error("active pd wrong");
  a_deep_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == st_idle && !gate && !sel_n && cmd[2:0] == 3'h3 |=> ##1 in_deep_sleep && need_reinit)
    else $error("deep sleep entry missed");
  a_tied_ignore: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ref_tied |=> state != st_cal || $past(state) == st_cal) else $error("tied pin calibrated");
  a_no_refresh_pd: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pd_idle || pd_active |-> !refresh_allowed) else $error("refresh in power-down");
  a_reset_default: assert property (@(posedge ref_clk) disable iff (!rst_n)
    imp_reset_req && state == st_idle |=> !impedance_calibrated && state == st_idle)
    else $error("impedance reset wrong");
  a_pd_exit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == st_idle_pd && gate && sel_n |=> state == st_idle ##1 buffers_on) else $error("pd exit");
  c_cal_done: cover property (@(posedge ref_clk) disable iff (!rst_n) state == st_cal ##1 state == st_idle);
  c_idle_pd: cover property (@(posedge ref_clk) disable iff (!rst_n) pd_idle);
  c_deep: cover property (@(posedge ref_clk) disable iff (!rst_n) in_deep_sleep ##1 !in_deep_sleep);
endmodule // lpd_core

// ### lpd_params.svh
// Constants for the power-down and impedance calibration block.
`ifndef LPD_PARAMS_SVH
`define LPD_PARAMS_SVH
`define CAL_MODE_ADDR 8'h0A
`define CAL_CODE_INIT 8'hFF
`define CAL_CODE_LONG 8'hAB
`define CAL_CODE_SHORT 8'h56
`define CAL_CODE_RESET 8'hC3
`define CLK_PERIOD_NS 50
`define INIT_CAL_NS 1000
`define LONG_CAL_NS 360
`define SHORT_CAL_NS 90
`define INIT_CAL_CYC ((`INIT_CAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LONG_CAL_CYC ((`LONG_CAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SHORT_CAL_CYC ((`SHORT_CAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAL_CNT_W 8
`endif

// ### lpd_pkg.sv
// Types shared by the power-down and impedance calibration block.
package lpd_pkg;
  typedef enum logic [2:0] {st_idle, st_active, st_cal, st_idle_pd, st_active_pd, st_deep} pwr_state_e;
  typedef enum logic [1:0] {imp_default, imp_calibrated} imp_state_e;
endpackage

// ### cmd_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
`timescale 1ns/10ps
module cmd_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // A bit changes only once the second and third stages agree.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dout <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  end
endmodule // cmd_sync

// ### lpd_ctrl_model.sv
// Controller model that drives the command pins of the block.
`timescale 1ns/10ps
`include "lpd_params.svh"
module lpd_ctrl_model (
  input wire logic ref_clk,
  output logic clk_gate,
  output logic select_n,
  output logic [3:0] cmd_rise,
  output logic [7:0] mode_addr,
  output logic [7:0] mode_data
);
  logic [7:0] cal_addr = `CAL_MODE_ADDR;
  initial begin
    clk_gate = 1'b1;
    select_n = 1'b1;
    cmd_rise = 4'h7;
    mode_addr = 8'h00;
    mode_data = 8'h00;
  end
  // Holds one pin state for n edges; unused command pins keep changing.
  task automatic drive(input logic g, input logic s, input logic [3:0] c, input logic [7:0] d, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      clk_gate = g;
      select_n = s;
      cmd_rise = s ? ~cmd_rise : c;
      mode_addr = s ? ~mode_addr : cal_addr;
      mode_data = d;
    end
  endtask
  task automatic nop(input int n);
    drive(1'b1, 1'b1, 4'h7, 8'h00, n);
  endtask
  task automatic cal(input logic [7:0] code);
    drive(1'b1, 1'b0, 4'h0, code, 5);
    nop(40);
  endtask
  task automatic pd(input int n);
    drive(1'b0, 1'b1, 4'h7, 8'h00, n);
  endtask
  task automatic deep(input logic b3);
    drive(1'b0, 1'b0, {b3, 3'b011}, 8'h00, 8);
  endtask
endmodule // lpd_ctrl_model

// ### dram_powerdown_impedance_cal_tb.sv
// Self-checking bench for the power-down and calibration block.
`timescale 1ns/10ps
`include "lpd_params.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module dram_powerdown_impedance_cal_tb;
  logic ref_clk = 1'b0, rst_n = 1'b0, row_open = 1'b0, ref_pin = 1'b0, init_done = 1'b0;
  logic clk_gate, select_n, buffers_on, pd_idle, pd_active, in_deep_sleep, need_reinit;
  logic cal_busy, refresh_allowed, impedance_calibrated, ro;
  logic [3:0] cmd_rise;
  logic [7:0] mode_addr, mode_data, code;
  logic [31:0] seed = 32'h0000_005D;
  int error_cnt = 0, checks = 0, cycles = 0, busy_n = 0;
  always #25 ref_clk = ~ref_clk;
  lpd_ctrl_model ctl (.ref_clk(ref_clk), .clk_gate(clk_gate), .select_n(select_n), .cmd_rise(cmd_rise),
    .mode_addr(mode_addr), .mode_data(mode_data));
  lpd_core dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_gate(clk_gate), .select_n(select_n),
    .cmd_rise(cmd_rise), .mode_addr(mode_addr), .mode_data(mode_data), .row_open(row_open),
    .impedance_ref_pin(ref_pin), .init_done(init_done), .buffers_on(buffers_on), .pd_idle(pd_idle),
    .pd_active(pd_active), .in_deep_sleep(in_deep_sleep), .need_reinit(need_reinit), .cal_busy(cal_busy),
    .refresh_allowed(refresh_allowed), .impedance_calibrated(impedance_calibrated));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function int cal_len(input logic [7:0] c);
    case (c)
      `CAL_CODE_INIT: return `INIT_CAL_CYC;
      `CAL_CODE_LONG: return `LONG_CAL_CYC;
      `CAL_CODE_SHORT: return `SHORT_CAL_CYC;
      default: return 0;
    endcase
  endfunction
  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cal_busy === 1'b1) busy_n++;
    if (cycles == 3000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic run_cal(input logic [7:0] c, input logic cal_exp);
    int busy_exp;
    busy_exp = (ref_pin || ctl.cal_addr != `CAL_MODE_ADDR) ? 0 : cal_len(c);
    busy_n = 0;
    ctl.cal(c);
    `CHK("busy cycles", busy_exp, busy_n)
    `CHK("calibrated", cal_exp, impedance_calibrated)
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    `CHK("buffers after reset", 1'b1, buffers_on)
    `CHK("refresh after reset", 1'b1, refresh_allowed)
    ctl.nop(4);
    run_cal(`CAL_CODE_INIT, 1'b1);
    run_cal(`CAL_CODE_RESET, 1'b0);
    run_cal(`CAL_CODE_LONG, 1'b1);
    run_cal(`CAL_CODE_SHORT, 1'b1);
    run_cal(`CAL_CODE_RESET, 1'b0);
    code = rnd();
    if (cal_len(code) != 0 || code == `CAL_CODE_RESET) code = 8'h00;
    run_cal(code, 1'b0);
    ctl.cal_addr = 8'(rnd());
    if (ctl.cal_addr == `CAL_MODE_ADDR) ctl.cal_addr = 8'h00;
    run_cal(`CAL_CODE_LONG, 1'b0);
    ctl.cal_addr = `CAL_MODE_ADDR;
    for (int t = 0; t < 2; t++) begin
      @(posedge ref_clk);
      #1 ref_pin = ~ref_pin;
      run_cal(`CAL_CODE_INIT, ~ref_pin);
    end
    for (int i = 0; i < 4; i++) begin
      ro = rnd();
      row_open = ro;
      ctl.nop(2);
      ctl.pd(8 + int'(rnd() % 4));
      `CHK("idle pd", ~ro, pd_idle)
      `CHK("active pd", ro, pd_active)
      `CHK("buffers in pd", 1'b0, buffers_on)
      `CHK("refresh in pd", 1'b0, refresh_allowed)
      ctl.nop(8);
      `CHK("idle after exit", 1'b0, pd_idle | pd_active)
      `CHK("buffers after exit", 1'b1, buffers_on)
    end
    row_open = 1'b0;
    for (int b = 0; b < 2; b++) begin
      ctl.deep(b[0]);
      `CHK("deep entry", 1'b1, in_deep_sleep)
      `CHK("cal lost", 1'b0, impedance_calibrated)
      ctl.nop(8);
      `CHK("reinit needed", 1'b1, need_reinit)
      init_done = ~init_done;
      ctl.nop(1);
      init_done = ~init_done;
      ctl.nop(6);
      `CHK("deep exit", 1'b0, in_deep_sleep | need_reinit)
    end
    close_out();
  end
endmodule // dram_powerdown_impedance_cal_tb
